//--- hw/fwp_decode.sv
// The implementer's own choices: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
module fwp_decode (
    // clock and reset
    input  wire logic             clk,
    input  wire logic             arst_n,
    // serial link pins
    input  wire fwp_pkg::fwp_spi_s spi_pins,
    output logic                  so,
    output logic                  so_oe,
    // program/erase verdict
    output fwp_pkg::fwp_op_s      op_rpt,
    // register port
    input  wire logic [3:0]       reg_addr,
    input  wire logic [31:0]      reg_wdata,
    input  wire logic             reg_wr,
    input  wire logic             reg_rd,
    output logic [31:0]           reg_rdata
);
    import fwp_pkg::*;

    // ----------------------------------------
    // state and decode nets
    // ----------------------------------------
    fwp_st_s               r_reg;      // registered state
    fwp_st_s               r_next;     // next state
    logic                  sck_rise;   // synced clock edges
    logic                  sck_fall;
    logic [7:0]            op_w;       // opcode of the frame
    logic [23:0]           adr_w;      // address of the frame
    logic                  is_erase;
    logic                  is_write;   // program or any erase
    logic                  is_rdlk;
    logic [22:0]           span_sz;    // bytes the command touches
    logic [22:0]           span_s;     // span start, inclusive
    logic [22:0]           span_e;     // span end, exclusive
    logic [22:0]           rsz;        // decoded range size
    logic [22:0]           rlo;
    logic [22:0]           rhi;
    logic                  std_prot;   // range scheme verdict
    logic                  ind_prot;   // lock bit verdict
    logic                  prot;
    logic [`FWP_NLOCK-1:0] hit;        // lock bits under the span
    logic [2:0]            ext_code;   // protect extent code
    logic                  bot_sel;    // 1 = span grows from zero
    logic                  gran;
    logic                  cpl_sel;    // complement the decoded span
    logic                  ind_sel;    // per-block lock scheme

    // ----------------------------------------
    // link edges and frame fields
    // ----------------------------------------
    // edges come from the second sync stage only
    assign sck_rise = r_reg.sck_p[1] & ~r_reg.sck_last;
    assign sck_fall = ~r_reg.sck_p[1] & r_reg.sck_last;
    // after 8 bits the opcode sits low, after 32 it sits high
    assign op_w  = (r_reg.cnt == `FWP_CMD_BITS) ? r_reg.shreg[7:0] : r_reg.shreg[31:24];
    assign adr_w = r_reg.shreg[23:0];

    // control fields
    assign ext_code = r_reg.ctrl[`FWP_EXT_MSB:0];
    assign bot_sel  = r_reg.ctrl[`FWP_BOT_BIT];
    assign gran     = r_reg.ctrl[`FWP_GRAN_BIT];
    assign cpl_sel  = r_reg.ctrl[`FWP_CPL_BIT];
    assign ind_sel  = r_reg.ctrl[`FWP_IND_BIT];

    // ----------------------------------------
    // span of the command
    // ----------------------------------------
    always_comb begin
        is_erase = 1'b1;
        is_rdlk  = 1'b0;
        case (op_w)
            `FWP_OP_ER4: begin
                span_sz = `FWP_SZ_4K;
            end
            `FWP_OP_ER32: begin
                span_sz = `FWP_SZ_32K;
            end
            `FWP_OP_ER64: begin
                span_sz = `FWP_SZ_64K;
            end
            `FWP_OP_CE_A, `FWP_OP_CE_B: begin
                span_sz = `FWP_SZ_ALL;
            end
            default: begin
                // program, lock and read-back look at one byte
                is_erase = 1'b0;
                is_rdlk  = (op_w == `FWP_OP_RDLK_A) || (op_w == `FWP_OP_RDLK_B);
                span_sz  = `FWP_SZ_1;
            end
        endcase
    end
    assign is_write = is_erase || (op_w == `FWP_OP_PROG);
    // an erase is aligned to its own size; the whole span is checked
    assign span_s = {1'b0, adr_w[21:0]} & ~(span_sz - `FWP_SZ_1);
    assign span_e = span_s + span_sz;

    // ----------------------------------------
    // range scheme decode
    // ----------------------------------------
    always_comb begin
        if (ext_code == 3'h0) begin
            rsz = 23'h00_0000;
        end else if (!gran) begin
            // 64 kB unit doubling, code 7 covers all
            rsz = (ext_code == 3'h7) ? `FWP_SZ_ALL :
                  (`FWP_SZ_64K << (ext_code - 3'h1));
        end else if (ext_code <= 3'h4) begin
            rsz = `FWP_SZ_4K << (ext_code - 3'h1);
        end else if (ext_code == 3'h5) begin
            // code 5 repeats the 32K span
            rsz = `FWP_SZ_32K;
        end else begin
            rsz = `FWP_SZ_ALL;
        end
        // complemented 4 kB: 32K/64K erases see the free end widened
        if (cpl_sel && gran && (ext_code != 3'h0) && (ext_code <= 3'h5) && is_erase &&
            ((span_sz == `FWP_SZ_32K) || (span_sz == `FWP_SZ_64K)) && (span_sz > rsz)) begin
            rsz = span_sz;
        end
        // top grows down from the end, bottom grows up from zero
        rlo = bot_sel ? 23'h00_0000 : (`FWP_SZ_ALL - rsz);
        rhi = bot_sel ? rsz : `FWP_SZ_ALL;
    end
    // plain: overlap protects; complemented: only a span inside is free
    assign std_prot = cpl_sel ? !((span_s >= rlo) && (span_e <= rhi))
                          : ((rsz != 23'h00_0000) && (span_s < rhi) && (span_e > rlo));

    // ----------------------------------------
    // lock bit map
    // ----------------------------------------
    // bits 0-15 bottom 4 kB, 16-31 top 4 kB, 32-93 middle 64 kB blocks
    for (genvar i = 0; i < `FWP_NLOCK; i++) begin : g_lock
        localparam logic [22:0] BLO = (i < `FWP_SUB_N) ? 23'(i * `FWP_SZ_4K) :
                                      (i < 2 * `FWP_SUB_N) ?
                                      23'(`FWP_TOP_BASE + (i - `FWP_SUB_N) * `FWP_SZ_4K) :
                                      23'((i - 2 * `FWP_SUB_N + 1) * `FWP_SZ_64K);
        localparam logic [22:0] BSZ = (i < 2 * `FWP_SUB_N) ? `FWP_SZ_4K : `FWP_SZ_64K;
        assign hit[i] = (BLO < span_e) && (23'(BLO + BSZ) > span_s);
    end
    assign ind_prot = |(r_reg.locks & hit);
    // scheme select
    assign prot = ind_sel ? ind_prot : std_prot;

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb begin
        r_next        = r_reg;
        r_next.op.go  = 1'b0;
        r_next.op.blk = 1'b0;
        r_next.rdata  = 32'h0000_0000;
        // two-stage synchronisers
        r_next.cs_p     = {r_reg.cs_p[0], spi_pins.cs_n};
        r_next.sck_p    = {r_reg.sck_p[0], spi_pins.sck};
        r_next.si_p     = {r_reg.si_p[0], spi_pins.si};
        r_next.sck_last = r_reg.sck_p[1];

        // register writes: only control is writable
        if (reg_wr && (reg_addr == `FWP_CTRL_OFS)) begin
            r_next.ctrl = reg_wdata[6:0];
        end
        // register reads, data the following cycle
        if (reg_rd) begin
            case (reg_addr)
                `FWP_CTRL_OFS: begin
                    r_next.rdata = {25'h000_0000, r_reg.ctrl};
                end
                `FWP_STAT_OFS: begin
                    r_next.rdata = {29'h0000_0000, (r_reg.st != ST_SHIFT),
                                    r_reg.last_go, r_reg.last_blk};
                end
                `FWP_LAST_OFS: begin
                    r_next.rdata = {r_reg.op.code, r_reg.op.addr};
                end
                default: begin
                    // unmapped reads as zero
                    r_next.rdata = 32'h0000_0000;
                end
            endcase
        end

        // frame engine
        case (r_reg.st)
            ST_SHIFT: begin
                // mode 0/3: sample on the rising edge
                if (sck_rise && !r_reg.cs_p[1]) begin
                    r_next.shreg = {r_reg.shreg[30:0], r_reg.si_p[1]};
                    r_next.cnt   = r_reg.cnt + 6'd1;
                    if (r_next.cnt == `FWP_CMD_BITS) begin
                        case (r_next.shreg[7:0])
                            `FWP_OP_GLOCK, `FWP_OP_GUNLOCK,
                            `FWP_OP_CE_A, `FWP_OP_CE_B: begin
                                r_next.st = ST_EVAL;
                            end
                            `FWP_OP_LOCK, `FWP_OP_UNLOCK, `FWP_OP_RDLK_A,
                            `FWP_OP_RDLK_B, `FWP_OP_PROG, `FWP_OP_ER4,
                            `FWP_OP_ER32, `FWP_OP_ER64: begin
                                r_next.st = ST_SHIFT;
                            end
                            default: begin
                                // not ours: sit out the frame
                                r_next.st = ST_WAIT;
                            end
                        endcase
                    end else if (r_next.cnt == `FWP_FRM_BITS) begin
                        r_next.st = ST_EVAL;
                    end
                end
            end
            ST_EVAL: begin
                r_next.st = ST_WAIT;
                if (op_w == `FWP_OP_LOCK) begin
                    r_next.locks = r_reg.locks | hit;
                end else if (op_w == `FWP_OP_UNLOCK) begin
                    r_next.locks = r_reg.locks & ~hit;
                end else if (op_w == `FWP_OP_GLOCK) begin
                    r_next.locks = `FWP_LOCK_RST;
                end else if (op_w == `FWP_OP_GUNLOCK) begin
                    r_next.locks = '0;
                end else if (is_rdlk) begin
                    // lock state in the lsb, msb goes out first
                    r_next.out_sh = {7'h00, ind_prot};
                    r_next.so     = 1'b0;
                    r_next.so_oe  = 1'b1;
                    r_next.st     = ST_SEND;
                end else if (is_write) begin
                    // refused writes leave the array alone and idle
                    r_next.op.blk   = prot;
                    r_next.op.go    = ~prot;
                    r_next.op.code  = op_w;
                    r_next.op.addr  = is_erase ? {2'b00, span_s[21:0]} : adr_w;
                    r_next.last_blk = prot;
                    r_next.last_go  = ~prot;
                end
            end
            ST_SEND: begin
                // shift out on falling edges; the byte repeats until deselect
                if (sck_fall) begin
                    r_next.so     = r_reg.out_sh[7];
                    r_next.out_sh = {r_reg.out_sh[6:0], r_reg.out_sh[7]};
                end
            end
            ST_WAIT: begin
                r_next.st = ST_WAIT;
            end
            default: begin
                r_next.st = ST_SHIFT;
            end
        endcase

        // deselect ends any frame; a short frame does nothing
        if (r_reg.cs_p[1]) begin
            r_next.st    = ST_SHIFT;
            r_next.cnt   = 6'd0;
            r_next.so_oe = 1'b0;
        end
    end

    // ----------------------------------------
    // state register
    // ----------------------------------------
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            r_reg          <= '0;
            r_reg.cs_p     <= 2'b11;
            r_reg.st       <= ST_SHIFT;
            r_reg.ctrl     <= `FWP_CTRL_RST;
            r_reg.locks    <= `FWP_LOCK_RST;
        end else begin
            r_reg <= r_next;
        end
    end

    // outputs
    assign so        = r_reg.so;
    assign so_oe     = r_reg.so_oe;
    assign op_rpt    = r_reg.op;
    assign reg_rdata = r_reg.rdata;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!arst_n);

    top_64k_a: assert property (
        (r_reg.st == ST_EVAL) && (r_reg.ctrl == 7'h01) && (op_w == `FWP_OP_PROG)
        |-> (prot == (adr_w[21:0] >= 22'h3f_0000)))
        else $error("top 64K range wrong");

    bot_2m_a: assert property (
        (r_reg.st == ST_EVAL) && (r_reg.ctrl == 7'h0e) && (op_w == `FWP_OP_PROG)
        |-> (prot == (adr_w[21:0] < 22'h20_0000)))
        else $error("bottom 2M range wrong");

    top_32k_a: assert property (
        (r_reg.st == ST_EVAL) && (r_reg.ctrl == 7'h15) && (op_w == `FWP_OP_PROG)
        |-> (prot == (adr_w[21:0] >= 22'h3f_8000)))
        else $error("4K top code 5 wrong");

    cmp_none_a: assert property (
        (r_reg.st == ST_EVAL) && (r_reg.ctrl[6:4] == 3'h2) && (ext_code == 3'h7) && is_write
        |-> !prot)
        else $error("complement code 7 protects");

    cmp_er32_a: assert property (
        (r_reg.st == ST_EVAL) && (r_reg.ctrl == 7'h31) && (op_w == `FWP_OP_ER32)
        |-> (prot == (adr_w[21:0] < 22'h3f_8000)))
        else $error("32K erase widening wrong");

    verdict_a: assert property (
        (r_reg.st == ST_EVAL) && is_write && (r_reg.cnt != 6'd0) && !r_reg.cs_p[1]
        |=> (op_rpt.blk == $past(prot)) && (op_rpt.go == !$past(prot)) && (r_reg.st == ST_WAIT))
        else $error("write verdict wrong");

    lock_set_a: assert property (
        (r_reg.st == ST_EVAL) && (op_w == `FWP_OP_LOCK)
        |=> ((r_reg.locks & $past(hit)) == $past(hit)) && ($countones($past(hit)) == 1))
        else $error("lock bit not set");

    unlock_clr_a: assert property (
        (r_reg.st == ST_EVAL) && (op_w == `FWP_OP_UNLOCK)
        |=> ((r_reg.locks & $past(hit)) == '0))
        else $error("lock bit not cleared");

    global_lock_a: assert property (
        (r_reg.st == ST_EVAL) && (op_w == `FWP_OP_GLOCK) && (r_reg.cnt == 6'd8)
        |=> (&r_reg.locks))
        else $error("global lock incomplete");

    lock_read_a: assert property (
        (r_reg.st == ST_EVAL) && is_rdlk && !r_reg.cs_p[1]
        |=> so_oe && (r_reg.out_sh == {7'h00, $past(ind_prot)}))
        else $error("lock read byte wrong");

    scheme_sel_a: assert property (
        ind_sel && (r_reg.st == ST_EVAL) |-> (prot == ind_prot))
        else $error("scheme select wrong");
endmodule

//--- hw/fwp_defs.svh
`ifndef FWP_DEFS_SVH
`define FWP_DEFS_SVH

// register map
`define FWP_CTRL_OFS   4'h0
`define FWP_STAT_OFS   4'h4
`define FWP_LAST_OFS   4'h8
// control fields
`define FWP_EXT_MSB    2
`define FWP_BOT_BIT    3
`define FWP_GRAN_BIT   4
`define FWP_CPL_BIT    5
`define FWP_IND_BIT    6
`define FWP_CTRL_RST   7'h00
// opcodes
`define FWP_OP_LOCK    8'h36
`define FWP_OP_UNLOCK  8'h39
`define FWP_OP_GLOCK   8'h7e
`define FWP_OP_GUNLOCK 8'h98
`define FWP_OP_RDLK_A  8'h3c
`define FWP_OP_RDLK_B  8'h3d
`define FWP_OP_PROG    8'h02
`define FWP_OP_ER4     8'h20
`define FWP_OP_ER32    8'h52
`define FWP_OP_ER64    8'hd8
`define FWP_OP_CE_A    8'h60
`define FWP_OP_CE_B    8'hc7
// array geometry
`define FWP_SZ_1       23'h00_0001
`define FWP_SZ_4K      23'h00_1000
`define FWP_SZ_32K     23'h00_8000
`define FWP_SZ_64K     23'h01_0000
`define FWP_SZ_ALL     23'h40_0000
`define FWP_TOP_BASE   23'h3f_0000
`define FWP_SUB_N      16
`define FWP_NLOCK      94
`define FWP_LOCK_RST   {`FWP_NLOCK{1'b1}}
// serial frame lengths
`define FWP_CMD_BITS   6'd8
`define FWP_FRM_BITS   6'd32
`endif

//--- hw/fwp_pkg.sv
`include "fwp_defs.svh"
package fwp_pkg;
    // serial pins from the host
    typedef struct packed {
        logic cs_n;
        logic sck;
        logic si;
    } fwp_spi_s;
    // verdict on one program or erase
    typedef struct packed {
        logic        go;
        logic        blk;
        logic [7:0]  code;
        logic [23:0] addr;
    } fwp_op_s;
    // one-hot frame states
    typedef enum logic [3:0] {
        ST_SHIFT = 4'b0001,
        ST_EVAL  = 4'b0010,
        ST_SEND  = 4'b0100,
        ST_WAIT  = 4'b1000
    } fwp_state_e;
    // whole state of the block
    typedef struct packed {
        logic [1:0]           cs_p;
        logic [1:0]           sck_p;
        logic [1:0]           si_p;
        logic                 sck_last;
        fwp_state_e           st;
        logic [5:0]           cnt;
        logic [31:0]          shreg;
        logic [7:0]           out_sh;
        logic                 so;
        logic                 so_oe;
        logic [`FWP_NLOCK-1:0] locks;
        logic [6:0]           ctrl;
        fwp_op_s              op;
        logic                 last_blk;
        logic                 last_go;
        logic [31:0]          rdata;
    } fwp_st_s;
endpackage

//--- testbench/flash_write_protect_decode_test.sv
`timescale 1ns/1ps
module flash_write_protect_decode_test;
    import fwp_pkg::*;
    // ----------------------------------------
    // signals
    // ----------------------------------------
    typedef struct packed {
        logic [6:0]  ctrl;
        logic [7:0]  op;
        logic [23:0] addr;
        logic [1:0]  exp;
    } fwp_row_s;
    localparam logic [1:0] BLK = 2'b10;  // refused
    localparam logic [1:0] GO  = 2'b01;  // allowed
    localparam logic [1:0] NO  = 2'b00;  // no verdict at all
    logic        clk;
    logic        arst_n;
    fwp_spi_s    spi;
    logic        so;
    logic        so_oe;
    fwp_op_s     op_rpt;
    logic [3:0]  reg_addr;
    logic [31:0] reg_wdata;
    logic        reg_wr;
    logic        reg_rd;
    logic [31:0] reg_rdata;
    logic [31:0] d;
    logic [31:0] cap;         // code and address at the last verdict
    int          n_go;
    int          n_blk;
    int          n_mismatch;
    int          tests_run;
    fwp_row_s    rows[$];
    // ----------------------------------------
    // instances
    // ----------------------------------------
    fwp_decode dut (.clk(clk), .arst_n(arst_n), .spi_pins(spi), .so(so), .so_oe(so_oe),
                    .op_rpt(op_rpt), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
                    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
    fwp_host_model host (.spi(spi), .so(so), .so_oe(so_oe));
    // 200 MHz clock
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    // count verdict pulses as they stand for one cycle
    always @(posedge clk) begin
        if (op_rpt.go === 1'b1 || op_rpt.blk === 1'b1) begin
            cap = {op_rpt.code, op_rpt.addr};
        end
        if (op_rpt.go === 1'b1) begin
            n_go++;
        end
        if (op_rpt.blk === 1'b1) begin
            n_blk++;
        end
    end
    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic reg_write(input logic [3:0] a, input logic [31:0] v);
        @(posedge clk);
        reg_addr  <= a;
        reg_wdata <= v;
        reg_wr    <= 1'b1;
        @(posedge clk);
        reg_wr    <= 1'b0;
    endtask
    // read data stand only in the cycle after the strobe edge
    task automatic reg_read(input logic [3:0] a, output logic [31:0] v);
        @(posedge clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk);
        reg_rd   <= 1'b0;
        @(negedge clk);
        v = reg_rdata;
    endtask
    // one frame, then exactly the expected verdict pulse or none
    task automatic op_check(input logic [7:0] op, input logic [23:0] a, input int nb,
                            input logic [1:0] exp);
        logic [7:0] rx;
        n_go = 0;
        n_blk = 0;
        host.xfer({op, a}, nb, 0, rx);
        repeat (4) @(posedge clk);
        check({n_blk[15:0], n_go[15:0]}, {15'h0, exp[1], 15'h0, exp[0]}, "verdict");
        if (exp != NO) begin
            check(cap, {op, a}, "code and address");
        end
    endtask
    task automatic lock_read(input logic [7:0] op, input logic [23:0] a, input logic [7:0] e);
        logic [7:0] rx;
        host.xfer({op, a}, 32, 8, rx);
        check({24'h0, rx}, {24'h0, e}, "lock byte");
    endtask
    task automatic do_reset();
        @(posedge clk);
        arst_n <= 1'b0;
        repeat (6) @(posedge clk);
        arst_n <= 1'b1;
        repeat (3) @(posedge clk);
    endtask
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // ----------------------------------------
    // watchdog
    // ----------------------------------------
    // about sixty frames of under 2 us each; twice that cuts a hang
    initial begin
        #250_000;
        n_mismatch++;
        tally_and_finish();
    end
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        {reg_addr, reg_wdata, reg_wr, reg_rd} = '0;
        arst_n = 1'b0;
        rows = '{
            '{7'h00, 8'h02, 24'h3f_ffff, GO},  '{7'h01, 8'h02, 24'h3f_0000, BLK},
            '{7'h01, 8'h02, 24'h3e_ffff, GO},  '{7'h06, 8'h02, 24'h20_0000, BLK},
            '{7'h06, 8'h02, 24'h1f_ffff, GO},  '{7'h07, 8'h02, 24'h00_0000, BLK},
            '{7'h0e, 8'h02, 24'h1f_ffff, BLK}, '{7'h0e, 8'h02, 24'h20_0000, GO},
            '{7'h09, 8'h02, 24'h00_ffff, BLK}, '{7'h09, 8'h02, 24'h01_0000, GO},
            '{7'h11, 8'h02, 24'h3f_f000, BLK}, '{7'h11, 8'h02, 24'h3f_efff, GO},
            '{7'h15, 8'h02, 24'h3f_8000, BLK}, '{7'h15, 8'h02, 24'h3f_7fff, GO},
            '{7'h16, 8'h02, 24'h00_0000, BLK}, '{7'h1c, 8'h02, 24'h00_7fff, BLK},
            '{7'h1c, 8'h02, 24'h00_8000, GO},  '{7'h20, 8'h02, 24'h3f_ffff, BLK},
            '{7'h27, 8'h02, 24'h00_0000, GO},  '{7'h21, 8'h02, 24'h3f_0000, GO},
            '{7'h21, 8'h02, 24'h3e_ffff, BLK}, '{7'h31, 8'h02, 24'h3f_f000, GO},
            '{7'h31, 8'h02, 24'h3f_efff, BLK}, '{7'h36, 8'h02, 24'h00_0000, GO},
            '{7'h31, 8'h52, 24'h3f_8000, GO},  '{7'h31, 8'h52, 24'h3f_0000, BLK},
            '{7'h31, 8'hd8, 24'h3f_0000, GO},  '{7'h31, 8'hd8, 24'h3e_0000, BLK},
            '{7'h39, 8'h52, 24'h00_0000, GO},  '{7'h39, 8'h52, 24'h00_8000, BLK},
            '{7'h39, 8'hd8, 24'h00_0000, GO},  '{7'h11, 8'hd8, 24'h3f_0000, BLK},
            '{7'h11, 8'h20, 24'h3f_e000, GO},  '{7'h01, 8'h60, 24'h00_0000, BLK},
            '{7'h00, 8'hc7, 24'h00_0000, GO}
        };                                      // tables of the range scheme, plain and complemented
        do_reset();
        reg_read(4'h0, d);
        check(d, 32'h0, "control at reset");
        foreach (rows[i]) begin
            reg_write(4'h0, {25'h0, rows[i].ctrl});
            op_check(rows[i].op, rows[i].addr, (rows[i].op inside {8'h60, 8'hc7}) ? 8 : 32,
                     rows[i].exp);
        end
        $display("range table done");
        // registers: read-only status, last verdict, unmapped, upper control bits
        reg_write(4'h0, 32'hffff_ffff);
        op_check(8'h02, 24'h12_3456, 32, BLK);
        reg_read(4'h0, d);
        check(d, 32'h0000_007f, "control width");
        reg_write(4'h4, 32'hffff_ffff);
        reg_read(4'h4, d);
        check(d, 32'h0000_0001, "status after refusal");
        reg_read(4'h8, d);
        check(d, 32'h0212_3456, "last operation");
        reg_read(4'hc, d);
        check(d, 32'h0, "unmapped read");
        $display("register test done");
        // per-block locks
        reg_write(4'h0, 32'h0000_0040);
        lock_read(8'h3c, 24'h3f_f000, 8'h01);
        op_check(8'h39, 24'h3f_f000, 32, NO);
        op_check(8'h02, 24'h3f_fabc, 32, GO);
        op_check(8'h02, 24'h3f_e000, 32, BLK);
        lock_read(8'h3d, 24'h3f_f123, 8'h00);
        op_check(8'h39, 24'h12_0000, 32, NO);
        op_check(8'h02, 24'h12_ffff, 32, GO);
        op_check(8'h02, 24'h13_0000, 32, BLK);
        op_check(8'hd8, 24'h3f_0000, 32, BLK);
        op_check(8'h36, 24'h12_8000, 32, NO);
        op_check(8'h02, 24'h12_0000, 32, BLK);
        op_check(8'h98, 24'h00_0000, 8, NO);
        op_check(8'h02, 24'h00_0000, 32, GO);
        op_check(8'h7e, 24'h00_0000, 8, NO);
        op_check(8'h02, 24'h3f_f000, 32, BLK);
        $display("lock test done");
        // unknown opcode and a frame cut short give no verdict
        reg_write(4'h0, 32'h0);
        op_check(8'h03, 24'h00_0000, 32, NO);
        op_check(8'h02, 24'h00_0000, 16, NO);
        op_check(8'h02, 24'h3f_f000, 32, GO);
        // reset in mid-run sets every lock again
        op_check(8'h98, 24'h00_0000, 8, NO);
        do_reset();
        reg_write(4'h0, 32'h0000_0040);
        op_check(8'h02, 24'h00_0000, 32, BLK);
        $display("reset test done");
        tally_and_finish();
    end
endmodule

//--- testbench/fwp_host_model.sv
`timescale 1ns/1ps
// host controller on the far side of the serial link
module fwp_host_model (
    // serial pins toward the block
    output fwp_pkg::fwp_spi_s spi,
    // lock byte coming back
    input  wire logic         so,
    input  wire logic         so_oe
);
    import fwp_pkg::*;
    // ----------------------------------------
    // idle pins
    // ----------------------------------------
    // sck stands low and cs_n high outside frames
    initial begin
        spi = '{cs_n: 1'b1, sck: 1'b0, si: 1'b0};
    end
    // ----------------------------------------
    // one frame
    // ----------------------------------------
    // nb bits out msb first, then nr bits back; a 24 ns half period keeps
    // every sck level at least four system clocks long
    task automatic xfer(input logic [31:0] frm, input int nb, input int nr,
                        output logic [7:0] rx);
        int i;
        rx = 8'h00;
        #3.1 spi.cs_n = 1'b0;
        for (i = 0; i < nb; i++) begin
            spi.si = frm[31-i];                    // opcode then address
            #24 spi.sck = 1'b1;
            #24 spi.sck = 1'b0;
        end
        for (i = 0; i < nr; i++) begin
            #24 spi.sck = 1'b1;
            rx = {rx[6:0], so_oe ? so : 1'b1};     // an undriven line reads high
            #24 spi.sck = 1'b0;
        end
        #24 spi.cs_n = 1'b1;
        spi.si = ~spi.si;                          // released line shows no stale bit
        #40;
    endtask
endmodule
